// *** src/rcau_pkg.sv ***
package rcau_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [11:0] ADDR_RESET_CAUSE_CONTROL = 12'h000;
    localparam logic [11:0] ADDR_STAT = 12'h004;

    localparam logic [15:0] RESET_CAUSE_CONTROL_RST_VAL = 16'h0003;
    localparam logic [15:0] RESET_CAUSE_CONTROL_WMASK   = 16'hf3ff;

    localparam int B_TRAP  = 15;
    localparam int B_ILOP  = 14;
    localparam int B_SBOR  = 13;
    localparam int B_CM    = 9;
    localparam int B_EXT   = 7;
    localparam int B_SWR   = 6;
    localparam int B_SWDT  = 5;
    localparam int B_WATCHDOG_TIMEOUT_FLAG  = 4;
    localparam int B_SLEEP = 3;
    localparam int B_IDLE  = 2;
    localparam int B_BOR   = 1;
    localparam int B_POR   = 0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // Oscillator source codes
    // ----------------------------------------------------------------
    localparam logic [2:0] OSC_FRC    = 3'h0;
    localparam logic [2:0] OSC_FRCPLL = 3'h1;
    localparam logic [2:0] OSC_XT     = 3'h2;
    localparam logic [2:0] OSC_XTPLL  = 3'h3;
    localparam logic [2:0] OSC_EC     = 3'h4;
    localparam logic [2:0] OSC_ECPLL  = 3'h5;
    localparam logic [2:0] OSC_SOSC   = 3'h6;
    localparam logic [2:0] OSC_LOW_POWER_INTERNAL_RC   = 3'h7;

    // ----------------------------------------------------------------
    // Timing, 200 MHz clock
    // ----------------------------------------------------------------
    localparam int CLK_MHZ  = 200;
    localparam int POWER_ON_DELAY_NS  = 10000;
    localparam int TFRC_NS  = 15000;
    localparam int TLPRC_NS = 20000;
    localparam int TLOCK_NS = 20000;
    localparam int TFSCM_NS = 10000;
    localparam int TPWRT_MS = 64;
    localparam int TW       = 24;
    localparam int OST_PERIODS = 1024;

    localparam logic [TW-1:0] POWER_ON_DELAY_CYC  = TW'((POWER_ON_DELAY_NS * CLK_MHZ + 999) / 1000);
    localparam logic [TW-1:0] TFRC_CYC  = TW'((TFRC_NS * CLK_MHZ + 999) / 1000);
    localparam logic [TW-1:0] TLPRC_CYC = TW'((TLPRC_NS * CLK_MHZ + 999) / 1000);
    localparam logic [TW-1:0] TLOCK_CYC = TW'((TLOCK_NS * CLK_MHZ + 999) / 1000);
    localparam logic [TW-1:0] TFSCM_CYC = TW'((TFSCM_NS * CLK_MHZ + 999) / 1000);
    localparam int            TPWRT_CYC = TPWRT_MS * CLK_MHZ * 1000;

    typedef enum logic [1:0] {RT_POR, RT_BOR, RT_OTHER} rcau_rtype_t;
    typedef enum logic [1:0] {SQ_IDLE, SQ_HOLD, SQ_CLKWAIT, SQ_RUN} rcau_seq_t;
    typedef enum logic [1:0] {CK_IDLE, CK_FIRST, CK_LOCK, CK_DONE} rcau_ck_t;

endpackage

// *** src/rcau_tmr_if.sv ***
`timescale 1ns/100ps
interface rcau_tmr_if;
    import rcau_pkg::*;
    logic          load;
    logic [TW-1:0] count;
    logic          done;
    modport ctl (output load, output count, input done);
    modport tmr (input load, input count, output done);
endinterface

// *** src/rcau_timer.sv ***
`timescale 1ns/100ps
module rcau_timer import rcau_pkg::*; (
    input wire logic sys_clk,
    input wire logic nrst,
    rcau_tmr_if.tmr  t
);
    logic [TW-1:0] cnt_q;
    logic          done_q;

    // Done is reloaded by every load (set only for a zero count), so a stale done never survives a restart
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q  <= '0;
            done_q <= 1'b0;
        end else if (t.load) begin
            cnt_q  <= t.count;
            done_q <= (t.count == '0);
        end else if (cnt_q != '0) begin
            cnt_q  <= cnt_q - TW'(1);
            done_q <= (cnt_q == TW'(1));
        end
    end

    assign t.done = done_q;
endmodule

// *** src/rcau_ost.sv ***
`timescale 1ns/100ps
module rcau_ost import rcau_pkg::*; (
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic start,
    input  wire logic oscTick,
    output logic      done
);
    logic [9:0] cnt_q;
    logic       run_q;
    logic       done_q;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q  <= '0;
            run_q  <= 1'b0;
            done_q <= 1'b0;
        end else if (start) begin
            cnt_q  <= '0;
            run_q  <= 1'b1;
            done_q <= 1'b0;
        end else if (run_q && oscTick) begin
            cnt_q <= cnt_q + 10'h001;
            if (cnt_q == 10'(OST_PERIODS - 1)) begin
                run_q  <= 1'b0;
                done_q <= 1'b1;
            end
        end
    end

    assign done = done_q;
endmodule

// *** src/rcau_seq.sv ***
`timescale 1ns/100ps
module rcau_seq import rcau_pkg::*; #(
    parameter logic [TW-1:0] POWERUP_TIMER_CYCLES = TW'(TPWRT_CYC)
) (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        brownoutEvt,
    input  wire logic        pinResetEvt,
    input  wire logic        watchdogEvt,
    input  wire logic        softResetEvt,
    input  wire logic        trapConflictEvt,
    input  wire logic        illegalOpEvt,
    input  wire logic        cfgMismatchEvt,
    input  wire logic        sleepEvt,
    input  wire logic        idleEvt,
    input  wire logic [2:0]  newOscFuse,
    input  wire logic [2:0]  curOscSel,
    input  wire logic        clkSwitchEn,
    input  wire logic        pwrtEn,
    input  wire logic        twoSpeedEn,
    input  wire logic [1:0]  wdtFuse,
    input  wire logic        oscTick,
    output logic             system_reset_signal,
    output logic             cpuRun,
    output logic             fscmEnable,
    output logic [2:0]       clkSrc,
    output logic             wdtEnable,
    output logic             softBorEnable,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    rcau_tmr_if tSys();
    rcau_tmr_if tClk();
    rcau_tmr_if tFsm();

    rcau_seq_t     seq_q;
    rcau_ck_t      ck_q;
    rcau_rtype_t   rtype_q;
    logic          porPend_q;
    logic          kick_q;
    logic [15:0]   reset_cause_control_q;
    logic [15:0]   rconSet;
    logic [15:0]   rconWr;
    logic [2:0]    clkSrc_q;
    logic [2:0]    startSrc;
    logic          needOst_q;
    logic          needLock_q;
    logic [TW-1:0] firstCyc;
    logic          firstOst;
    logic          firstLock;
    logic          ostStart;
    logic          ostDone;
    logic          firstDone;
    logic          anyEvt;
    logic          system_reset_signal_q;
    logic          cpuRun_q;
    logic          fscmEn_q;
    logic          wdtEn_q;
    logic          awready_q;
    logic          wready_q;
    logic          bvalid_q;
    logic [1:0]    bresp_q;
    logic [11:0]   awaddr_q;
    logic [31:0]   wdata_q;
    logic [3:0]    wstrb_q;
    logic          arready_q;
    logic          rvalid_q;
    logic [31:0]   rdata_q;
    logic [1:0]    rresp_q;
    logic          doWrite;
    logic          wrRcon;

    assign anyEvt = brownoutEvt | pinResetEvt | watchdogEvt | softResetEvt
                  | trapConflictEvt | illegalOpEvt | cfgMismatchEvt;

    // ----------------------------------------------------------------
    // Reset cause capture
    // ----------------------------------------------------------------
    // POR and BOR win over the rest; the others share the zero-delay path
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            porPend_q <= 1'b1;
            kick_q    <= 1'b0;
            rtype_q   <= RT_POR;
        end else begin
            porPend_q <= 1'b0;
            kick_q    <= porPend_q | anyEvt;
            if (porPend_q) begin
                rtype_q <= RT_POR;
            end else if (brownoutEvt) begin
                rtype_q <= RT_BOR;
            end else if (anyEvt) begin
                rtype_q <= RT_OTHER;
            end
        end
    end

    // ----------------------------------------------------------------
    // Clock source selection
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            clkSrc_q <= OSC_FRC;
        end else if (porPend_q || brownoutEvt || !clkSwitchEn) begin
            if (porPend_q || anyEvt) begin
                clkSrc_q <= newOscFuse;
            end
        end else if (anyEvt) begin
            clkSrc_q <= curOscSel;
        end
    end

    // Two-speed start runs the fast RC first, whatever the fuse picked
    assign startSrc = twoSpeedEn ? OSC_FRC : clkSrc_q;

    always_comb begin
        firstCyc  = '0;
        firstOst  = 1'b0;
        firstLock = 1'b0;
        case (startSrc)
            OSC_FRC: begin
                firstCyc = TFRC_CYC;
            end
            OSC_FRCPLL: begin
                firstCyc  = TFRC_CYC;
                firstLock = 1'b1;
            end
            OSC_XT, OSC_SOSC: begin
                firstOst = 1'b1;
            end
            OSC_XTPLL: begin
                // BOR restarts on the fast RC ahead of the PLL
                if (rtype_q == RT_BOR) begin
                    firstCyc = TFRC_CYC;
                end else begin
                    firstOst = 1'b1;
                end
                firstLock = 1'b1;
            end
            OSC_ECPLL: begin
                firstLock = 1'b1;
            end
            OSC_LOW_POWER_INTERNAL_RC: begin
                firstCyc = TLPRC_CYC;
            end
            default: begin
                firstCyc = '0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Delay timers
    // ----------------------------------------------------------------
    // System hold and clock start-up are loaded on the same kick
    always_comb begin
        tSys.load  = kick_q;
        tSys.count = '0;
        if (rtype_q == RT_POR) begin
            tSys.count = POWER_ON_DELAY_CYC + (pwrtEn ? POWERUP_TIMER_CYCLES : '0);
        end else if (rtype_q == RT_BOR) begin
            tSys.count = pwrtEn ? POWERUP_TIMER_CYCLES : '0;
        end
    end

    assign firstDone  = needOst_q ? ostDone : tClk.done;
    assign ostStart   = kick_q && firstOst;
    assign tClk.load  = kick_q || (ck_q == CK_FIRST && firstDone && needLock_q);
    assign tClk.count = kick_q ? firstCyc : TLOCK_CYC;
    assign tFsm.load  = (seq_q == SQ_HOLD) && tSys.done;
    assign tFsm.count = TFSCM_CYC;

    rcau_timer u_tSys (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .t       (tSys.tmr)
    );

    rcau_timer u_tClk (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .t       (tClk.tmr)
    );

    rcau_timer u_tFsm (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .t       (tFsm.tmr)
    );

    rcau_ost u_ost (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .start   (ostStart),
        .oscTick (oscTick),
        .done    (ostDone)
    );

    // ----------------------------------------------------------------
    // Clock start-up sequence
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ck_q       <= CK_IDLE;
            needOst_q  <= 1'b0;
            needLock_q <= 1'b0;
        end else if (kick_q) begin
            ck_q       <= CK_FIRST;
            needOst_q  <= firstOst;
            needLock_q <= firstLock;
        end else begin
            case (ck_q)
                CK_FIRST: begin
                    if (firstDone) begin
                        ck_q <= needLock_q ? CK_LOCK : CK_DONE;
                    end
                end
                CK_LOCK: begin
                    if (tClk.done) begin
                        ck_q <= CK_DONE;
                    end
                end
                CK_IDLE, CK_DONE: begin
                    ck_q <= ck_q;
                end
                default: begin
                    ck_q <= CK_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Release sequence
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            seq_q    <= SQ_IDLE;
            system_reset_signal_q <= 1'b1;
            cpuRun_q <= 1'b0;
            fscmEn_q <= 1'b0;
        end else if (kick_q) begin
            seq_q    <= SQ_HOLD;
            system_reset_signal_q <= 1'b1;
            cpuRun_q <= 1'b0;
            fscmEn_q <= 1'b0;
        end else begin
            case (seq_q)
                SQ_HOLD: begin
                    if (tSys.done) begin
                        seq_q    <= SQ_CLKWAIT;
                        system_reset_signal_q <= 1'b0;
                    end
                end
                SQ_CLKWAIT: begin
                    if (ck_q == CK_DONE) begin
                        seq_q    <= SQ_RUN;
                        cpuRun_q <= 1'b1;
                    end
                end
                SQ_IDLE, SQ_RUN: begin
                    seq_q <= seq_q;
                end
                default: begin
                    seq_q <= SQ_IDLE;
                end
            endcase
            if (seq_q != SQ_HOLD && seq_q != SQ_IDLE && tFsm.done) begin
                fscmEn_q <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Reset cause register
    // ----------------------------------------------------------------
    always_comb begin
        rconSet         = '0;
        rconSet[B_TRAP] = trapConflictEvt;
        rconSet[B_ILOP] = illegalOpEvt;
        rconSet[B_CM]   = cfgMismatchEvt;
        rconSet[B_EXT]  = pinResetEvt;
        rconSet[B_SWR]  = softResetEvt;
        rconSet[B_WATCHDOG_TIMEOUT_FLAG] = watchdogEvt;
        rconSet[B_SLEEP] = sleepEvt;
        rconSet[B_IDLE] = idleEvt;
        rconSet[B_BOR]  = brownoutEvt;
    end

    assign rconWr = {s_axi_wstrb_hi(wstrb_q) ? wdata_q[15:8] : reset_cause_control_q[15:8],
                     wstrb_q[0] ? wdata_q[7:0] : reset_cause_control_q[7:0]};

    // A set in the write cycle wins over the written value
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            reset_cause_control_q <= RESET_CAUSE_CONTROL_RST_VAL;
        end else if (wrRcon) begin
            reset_cause_control_q <= (rconWr & RESET_CAUSE_CONTROL_WMASK) | rconSet;
        end else begin
            reset_cause_control_q <= reset_cause_control_q | rconSet;
        end
    end

    // Unprogrammed fuse pair reads 2'b11
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wdtEn_q <= 1'b1;
        end else begin
            wdtEn_q <= (wdtFuse == 2'b11) || reset_cause_control_q[B_SWDT];
        end
    end

    function automatic logic s_axi_wstrb_hi(input logic [3:0] s);
        return s[1];
    endfunction

    // ----------------------------------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------------------------------
    assign doWrite = !awready_q && !wready_q && !bvalid_q;
    assign wrRcon  = doWrite && (awaddr_q == ADDR_RESET_CAUSE_CONTROL);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
        end else begin
            if (awready_q && s_axi_awvalid) begin
                awready_q <= 1'b0;
                awaddr_q  <= s_axi_awaddr;
            end
            if (wready_q && s_axi_wvalid) begin
                wready_q <= 1'b0;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (doWrite) begin
                bvalid_q <= 1'b1;
                bresp_q  <= (awaddr_q == ADDR_RESET_CAUSE_CONTROL || awaddr_q == ADDR_STAT)
                            ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_q && s_axi_bready) begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= RESP_OKAY;
        end else if (arready_q && s_axi_arvalid) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rresp_q   <= RESP_OKAY;
            case (s_axi_araddr)
                ADDR_RESET_CAUSE_CONTROL: rdata_q <= {16'h0000, reset_cause_control_q};
                ADDR_STAT: rdata_q <= {24'h000000, clkSrc_q, wdtEn_q,
                                       fscmEn_q, cpuRun_q, system_reset_signal_q, 1'b0};
                default: begin
                    rdata_q <= '0;
                    rresp_q <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign system_reset_signal        = system_reset_signal_q;
    assign cpuRun        = cpuRun_q;
    assign fscmEnable    = fscmEn_q;
    assign clkSrc        = clkSrc_q;
    assign wdtEnable     = wdtEn_q;
    assign softBorEnable = reset_cause_control_q[B_SBOR];
    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
endmodule

// *** dv/rcau_seq_monitor.sv ***
`timescale 1ns/100ps
module rcau_seq_chk import rcau_pkg::*; (
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic        pinResetEvt,
    input wire logic [1:0]  wdtFuse,
    input wire logic        system_reset_signal,
    input wire logic        cpuRun,
    input wire logic        fscmEnable,
    input wire logic        wdtEnable,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic [11:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid
);
    logic [TW-1:0] lowCnt_q;
    logic [11:0]   rdAddr_q;
    // Cycles since release; saturates, never wraps
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst)
            lowCnt_q <= '0;
        else if (system_reset_signal)
            lowCnt_q <= '0;
        else if (!lowCnt_q[TW-1])
            lowCnt_q <= lowCnt_q + 1'b1;
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst)
            rdAddr_q <= '0;
        else if (s_axi_arvalid && s_axi_arready)
            rdAddr_q <= s_axi_araddr;
    end
    // ----
    // Checks
    // ----
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    a_write_resp: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_read_resp: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read response late");
    a_cpu_gate: assert property (
        $rose(cpuRun) |-> !system_reset_signal && !$past(system_reset_signal)) else $error("code ran under reset");
    a_fail_safe_clock_monitor_delay: assert property (
        $rose(fscmEnable) |-> lowCnt_q >= TFSCM_CYC) else $error("monitor started early");
    a_event_restart: assert property (
        pinResetEvt |-> ##[1:4] system_reset_signal) else $error("event did not reset");
    a_wdt_forced: assert property (
        wdtFuse == 2'h3 && $past(wdtFuse) == 2'h3 |-> wdtEnable) else $error("watchdog off");
    a_unused_zero: assert property (
        s_axi_rvalid && rdAddr_q == ADDR_RESET_CAUSE_CONTROL |-> s_axi_rdata[31:16] == 16'h0000
        && s_axi_rdata[11:10] == 2'h0) else $error("unused bits set");
    a_unmapped_err: assert property (
        s_axi_rvalid && rdAddr_q == 12'h008 |-> s_axi_rresp == RESP_SLVERR)
        else $error("unmapped read not refused");
    cover property ($rose(cpuRun));
    cover property ($rose(fscmEnable));
    cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule
bind rcau_seq rcau_seq_chk u_chk (.*);

// *** dv/rcau_osc_model.sv ***
`timescale 1ns/100ps
module rcau_osc_model #(
    parameter int DIV = 3
) (
    input  wire logic sys_clk,
    input  wire logic nrst,
    output logic      oscTick
);
    logic [7:0] cnt_q;
    // One tick per crystal period for the start-up count
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q   <= '0;
            oscTick <= 1'b0;
        end else begin
            cnt_q   <= (cnt_q == 8'(DIV - 1)) ? 8'h00 : cnt_q + 8'h01;
            oscTick <= (cnt_q == 8'(DIV - 1));
        end
    end
endmodule

// *** dv/rcau_seq_tb_top.sv ***
`timescale 1ns/100ps
module rcau_seq_tb_top import rcau_pkg::*; ;
    typedef struct {
        int         ev;
        logic       csw;
        logic       ts;
        logic       pw;
        logic [2:0] fuse;
        logic [2:0] src;
        int         hold;
        int         clk;
    } rcau_row_t;
    rcau_row_t rows [13] = '{
        '{0, 1, 0, 1, OSC_FRC, OSC_FRC, 20, 3000}, '{0, 1, 0, 1, OSC_XTPLL, OSC_XTPLL, 20, 7000},
        '{0, 1, 0, 1, OSC_XT, OSC_XT, 20, 3068}, '{0, 1, 0, 1, OSC_ECPLL, OSC_ECPLL, 20, 4000},
        '{0, 1, 0, 0, OSC_LOW_POWER_INTERNAL_RC, OSC_LOW_POWER_INTERNAL_RC, 0, 4000}, '{0, 1, 1, 1, OSC_XT, OSC_XT, 20, 3000},
        '{1, 1, 0, 1, OSC_FRC, OSC_EC, 0, 0}, '{2, 1, 0, 1, OSC_FRC, OSC_EC, 0, 0},
        '{3, 1, 0, 1, OSC_FRC, OSC_EC, 0, 0}, '{4, 1, 0, 1, OSC_FRC, OSC_EC, 0, 0},
        '{5, 1, 0, 1, OSC_FRC, OSC_EC, 0, 0}, '{6, 1, 0, 1, OSC_FRC, OSC_EC, 0, 0},
        '{1, 0, 0, 1, OSC_FRCPLL, OSC_FRCPLL, 0, 7000}};
    int          fb [7] = '{1, 7, 4, 6, 15, 14, 9};
    int          nMismatch, totalChecks, cyc;
    logic        sys_clk, nrst, clkSwitchEn, pwrtEn, twoSpeedEn, oscTick;
    logic        system_reset_signal, cpuRun, fscmEnable, wdtEnable, softBorEnable;
    logic [8:0]  evt;
    logic [2:0]  newOscFuse, curOscSel, clkSrc;
    logic [1:0]  wdtFuse, s_axi_bresp, s_axi_rresp;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    rcau_seq #(.POWERUP_TIMER_CYCLES(TW'(20))) dut (.*, .brownoutEvt(evt[0]), .pinResetEvt(evt[1]),
        .watchdogEvt(evt[2]), .softResetEvt(evt[3]), .trapConflictEvt(evt[4]),
        .illegalOpEvt(evt[5]), .cfgMismatchEvt(evt[6]), .sleepEvt(evt[7]), .idleEvt(evt[8]));
    rcau_osc_model #(.DIV(3)) u_osc (.sys_clk(sys_clk), .nrst(nrst), .oscTick(oscTick));
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // ----
    // Tasks
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            nMismatch++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // Latency slack of a few cycles is the designer's
    task automatic chk_rng(input int got, input int lo);
        chk(32'((got >= lo && got <= lo + 16) ? lo : got), 32'(lo));
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, exp);
    endtask
    task automatic measure(output int tH, output int tC);
        tH = 0;
        tC = 0;
        while (cpuRun === 1'b1) begin
            @(negedge sys_clk);
            tC++;
        end
        while (cpuRun !== 1'b1) begin
            @(negedge sys_clk);
            tC++;
            if (system_reset_signal === 1'b1) tH++;
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", totalChecks, nMismatch);
        if (nMismatch == 0 && totalChecks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 80000) begin
            nMismatch++;
            finish_test();
        end
    end
    initial begin
        int tH, tC;
        {nrst, evt, clkSwitchEn, twoSpeedEn, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        {pwrtEn, wdtFuse, s_axi_wstrb, s_axi_wdata} = {3'h7, 4'hf, 32'h0};
        {newOscFuse, curOscSel} = {OSC_FRC, OSC_EC};
        repeat (10) @(posedge sys_clk);
        nrst <= 1'b1;
        measure(tH, tC);
        chk_rng(tH, 2020);
        chk_rng(tC, 3000);
        rdchk(ADDR_RESET_CAUSE_CONTROL, 32'h3);
        foreach (rows[i]) begin
            @(posedge sys_clk);
            {clkSwitchEn, twoSpeedEn, pwrtEn} <= {rows[i].csw, rows[i].ts, rows[i].pw};
            newOscFuse <= rows[i].fuse;
            wr(ADDR_RESET_CAUSE_CONTROL, 32'h0);
            evt[rows[i].ev] <= 1'b1;
            @(posedge sys_clk);
            evt <= '0;
            measure(tH, tC);
            chk_rng(tH, rows[i].hold);
            chk_rng(tC, rows[i].hold > rows[i].clk ? rows[i].hold : rows[i].clk);
            chk(32'(clkSrc), 32'(rows[i].src));
            rdchk(ADDR_RESET_CAUSE_CONTROL, 32'h1 << fb[rows[i].ev]);
        end
        wr(ADDR_RESET_CAUSE_CONTROL, 32'hffff);
        rdchk(ADDR_RESET_CAUSE_CONTROL, 32'hf3ff);
        chk(32'({cpuRun, softBorEnable}), 32'h3);
        rdchk(12'h008, 32'h0);
        wr(ADDR_RESET_CAUSE_CONTROL, 32'h0);
        evt[8:7] <= 2'h3;
        @(posedge sys_clk);
        evt <= '0;
        rdchk(ADDR_RESET_CAUSE_CONTROL, 32'hc);
        wdtFuse <= 2'h0;
        wr(ADDR_RESET_CAUSE_CONTROL, 32'h0);
        repeat (2) @(posedge sys_clk);
        chk(32'(wdtEnable), 32'h0);
        wdtFuse <= 2'h3;
        nrst <= 1'b0;
        @(posedge sys_clk);
        nrst <= 1'b1;
        measure(tH, tC);
        chk(32'(wdtEnable), 32'h1);
        rdchk(ADDR_RESET_CAUSE_CONTROL, 32'h3);
        rdchk(ADDR_STAT, 32'h3c);
        finish_test();
    end
endmodule
